// [rtl/sbrg_pkg.sv]
// Purpose: Shared constants and types for the serial baud rate generator.
// Assumes: Registers sit in byte lane 0 of aligned 32-bit Avalon words, save the status count in lane 1.
// Notes:   Constants and types only; no logic lives here.
package sbrg_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] SBRG_OFS_TXCTL = 4'h0;
  localparam logic [3:0] SBRG_OFS_RXCTL = 4'h4;
  localparam logic [3:0] SBRG_OFS_DIV = 4'h8;
  localparam logic [3:0] SBRG_OFS_STAT = 4'hC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SBRG_TX_CLKSRC = 7;
  localparam int SBRG_TX_SYNC = 4;
  localparam int SBRG_TX_HISPEED = 2;
  localparam int SBRG_RX_PORTEN = 7;
  localparam int SBRG_ST_RXLEVEL = 0;
  localparam int SBRG_ST_ACTIVE = 1;
  localparam int SBRG_ST_COUNT = 8;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SBRG_TXCTL_RST = 8'h00;
  localparam logic [7:0] SBRG_RXCTL_RST = 8'h00;
  localparam logic [7:0] SBRG_DIV_RST = 8'h00;
  localparam logic [7:0] SBRG_TXCTL_WMASK = 8'hF5;
  localparam logic [7:0] SBRG_RXCTL_WMASK = 8'hF8;
  // Shift register empty flag always reads set: no transmitter here
  localparam logic [7:0] SBRG_TXCTL_ROSET = 8'h02;

  // ----------------------------------------------------------------
  // Prescale ratios
  // ----------------------------------------------------------------
  localparam logic [5:0] SBRG_LAST_R4 = 6'h03;
  localparam logic [5:0] SBRG_LAST_R16 = 6'h0F;
  localparam logic [5:0] SBRG_LAST_R64 = 6'h3F;
  localparam logic [1:0] SBRG_TCY_LAST = 2'h3;

  typedef enum logic [1:0] {
    SBRG_RATIO4,
    SBRG_RATIO16,
    SBRG_RATIO64
  } sbrg_ratio_e;

endpackage

// [rtl/sbrg_prescaler.sv]
// Purpose: Instruction-cycle base and 4/16/64 prescaler for the timer.
// Assumes: Ratio select is steady except across a clear.
// Notes:   Clear returns the count to zero on the next edge.
`timescale 1ns/10ps
module sbrg_prescaler (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire sbrg_pkg::sbrg_ratio_e ratioSel,
  // Ticks
  output logic cycTick,
  output logic presTick
);
  import sbrg_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
  } sbrg_pre_s;

  sbrg_pre_s q;
  sbrg_pre_s d;
  logic [5:0] lastCnt;

  function automatic logic [5:0] lastOf(sbrg_ratio_e sel);
    case (sel)
      SBRG_RATIO4: lastOf = SBRG_LAST_R4;
      SBRG_RATIO16: lastOf = SBRG_LAST_R16;
      default: lastOf = SBRG_LAST_R64;
    endcase
  endfunction

  always_comb begin
    lastCnt = lastOf(ratioSel);
    // Every ratio is a multiple of four cycles
    cycTick = !clear && (q.cnt[1:0] == SBRG_TCY_LAST);
    presTick = !clear && (q.cnt == lastCnt);
    d = q;
    if (clear || presTick) begin
      d.cnt = 6'h00;
    end else begin
      d.cnt = q.cnt + 6'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pres_spacing;
    @(posedge core_clk) disable iff (rst)
      presTick |=> (!presTick || clear) [*3];
  endproperty
  a_pres_spacing: assert property (p_pres_spacing)
    else $error("prescaled ticks closer than four cycles");

  property p_pres_slow;
    @(posedge core_clk) disable iff (rst)
      (presTick && ratioSel == SBRG_RATIO64) |=> !presTick [*8];
  endproperty
  a_pres_slow: assert property (p_pres_slow)
    else $error("slow ratio tick came too early");

endmodule

// [rtl/sbrg_top.sv]
// Purpose: Baud rate generator with receive majority sampler, Avalon slave.
// Assumes: Avalon-MM master holds each request until waitrequest is low.
// Notes:   Every request is answered one cycle after it is first seen.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module sbrg_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial side
  input wire logic serialReceivePin,
  output logic baudTick,
  output logic rxLevel,
  output logic rateActive
);
  import sbrg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic waitReq;
    logic [31:0] rdata;
    logic [7:0] txCtl;
    logic [7:0] rxCtl;
    logic [7:0] divisor;
    logic [7:0] count;
    logic baudTick;
    logic active;
    logic [1:0] rxSync;
    logic [2:0] smp;
    logic rxLevel;
  } sbrg_state_s;

  sbrg_state_s q;
  sbrg_state_s d;

  logic accept;
  logic wrDiv;
  logic portEn;
  logic syncMode;
  logic master;
  logic preClear;
  logic cycTick;
  logic presTick;
  sbrg_ratio_e ratioSel;

  function automatic logic [31:0] readMux(logic [3:0] adr, sbrg_state_s s);
    readMux = 32'h0000_0000;
    case (adr)
      SBRG_OFS_TXCTL: readMux[7:0] = s.txCtl | SBRG_TXCTL_ROSET;
      SBRG_OFS_RXCTL: readMux[7:0] = s.rxCtl;
      SBRG_OFS_DIV: readMux[7:0] = s.divisor;
      SBRG_OFS_STAT: begin
        readMux[SBRG_ST_RXLEVEL] = s.rxLevel;
        readMux[SBRG_ST_ACTIVE] = s.active;
        readMux[SBRG_ST_COUNT +: 8] = s.count;
      end
      default: readMux = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    portEn = q.rxCtl[SBRG_RX_PORTEN];
    syncMode = q.txCtl[SBRG_TX_SYNC];
    // Clock source select matters only in synchronous mode
    master = !syncMode || q.txCtl[SBRG_TX_CLKSRC];
    // Sync uses the 4x base; high-speed select ignored there
    if (syncMode) begin
      ratioSel = SBRG_RATIO4;
    end else if (q.txCtl[SBRG_TX_HISPEED]) begin
      ratioSel = SBRG_RATIO16;
    end else begin
      ratioSel = SBRG_RATIO64;
    end
  end

  // ----------------------------------------------------------------
  // Bus and generator next state
  // ----------------------------------------------------------------
  always_comb begin
    // A request is taken on the edge where waitrequest is seen low
    accept = !q.waitReq && (avs_read || avs_write);
    wrDiv = accept && avs_write && avs_byteenable[0] &&
            (avs_address == SBRG_OFS_DIV);
    // Prescaler restarts with the timer so a new rate starts clean
    preClear = wrDiv || !portEn;
    d = q;

    d.waitReq = !(q.waitReq && (avs_read || avs_write));
    d.rdata = 32'h0000_0000;
    if (q.waitReq && avs_read) begin
      d.rdata = readMux(avs_address, q);
    end
    if (accept && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        SBRG_OFS_TXCTL: d.txCtl = avs_writedata[7:0] & SBRG_TXCTL_WMASK;
        SBRG_OFS_RXCTL: d.rxCtl = avs_writedata[7:0] & SBRG_RXCTL_WMASK;
        SBRG_OFS_DIV: d.divisor = avs_writedata[7:0];
        default: d.divisor = q.divisor;
      endcase
    end

    // Up-counter: count 0..n prescaled periods, then wrap
    d.baudTick = 1'b0;
    d.active = portEn && master;
    if (preClear) begin
      d.count = 8'h00;
    end else if (presTick) begin
      if (q.count == q.divisor) begin
        d.count = 8'h00;
        d.baudTick = master;
      end else begin
        d.count = q.count + 8'h01;
      end
    end

    // Pin passes two flops before the sampler looks at it
    d.rxSync = {q.rxSync[0], serialReceivePin};
    if (!portEn) begin
      d.smp = 3'b111;
      d.rxLevel = 1'b1;
    end else if (cycTick) begin
      d.smp = {q.smp[1:0], q.rxSync[1]};
      // Two of three samples decide the level
      d.rxLevel = (q.smp[0] & q.smp[1]) | (q.smp[1] & q.smp[2]) |
                  (q.smp[0] & q.smp[2]);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q.waitReq <= 1'b1;
      q.rdata <= 32'h0000_0000;
      q.txCtl <= SBRG_TXCTL_RST;
      q.rxCtl <= SBRG_RXCTL_RST;
      q.divisor <= SBRG_DIV_RST;
      q.count <= 8'h00;
      q.baudTick <= 1'b0;
      q.active <= 1'b0;
      q.rxSync <= 2'b11;
      q.smp <= 3'b111;
      q.rxLevel <= 1'b1;
    end else begin
      q <= d;
    end
  end

  sbrg_prescaler u_pre (
    .core_clk(core_clk),
    .rst(rst),
    .clear(preClear),
    .ratioSel(ratioSel),
    .cycTick(cycTick),
    .presTick(presTick)
  );

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitReq;
  assign baudTick = q.baudTick;
  assign rxLevel = q.rxLevel;
  assign rateActive = q.active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_div_clear;
    @(posedge core_clk) disable iff (rst)
      wrDiv |=> (q.count == 8'h00) && !q.baudTick;
  endproperty
  a_div_clear: assert property (p_div_clear)
    else $error("divisor write did not clear the timer");

  property p_port_off;
    @(posedge core_clk) disable iff (rst)
      !portEn ##1 !portEn |-> (q.count == 8'h00) && !q.baudTick;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("generator ran while port disabled");

  property p_slave_quiet;
    @(posedge core_clk) disable iff (rst)
      (syncMode && !q.txCtl[SBRG_TX_CLKSRC]) |=> !q.baudTick;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("tick produced in slave mode");

  property p_wrap;
    @(posedge core_clk) disable iff (rst)
      q.baudTick |-> (q.count == 8'h00) && ($past(q.count) == q.divisor);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("tick not at terminal count");

  property p_sync_ratio;
    @(posedge core_clk) disable iff (rst)
      syncMode |-> ratioSel == SBRG_RATIO4;
  endproperty
  a_sync_ratio: assert property (p_sync_ratio)
    else $error("sync mode not on four-cycle base");

  property p_async_ratio;
    @(posedge core_clk) disable iff (rst)
      (!syncMode && q.txCtl[SBRG_TX_HISPEED]) |-> ratioSel == SBRG_RATIO16;
  endproperty
  a_async_ratio: assert property (p_async_ratio)
    else $error("high speed ratio not selected");

  property p_majority;
    @(posedge core_clk) disable iff (rst)
      (portEn && cycTick && q.smp == 3'b000) |=> !q.rxLevel;
  endproperty
  a_majority: assert property (p_majority)
    else $error("majority of low samples not resolved low");

  property p_answer;
    @(posedge core_clk) disable iff (rst)
      (q.waitReq && (avs_read || avs_write)) |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus request not answered in one cycle");

endmodule

// [verif/sbrg_rx_peer.sv]
// Purpose: Far-side serial device driving the receive line.
// Assumes: The bench picks the level and any glitch, and how many cycles it lasts.
// Notes:   The line is never left floating; the device always drives it.
`timescale 1ns/10ps
module sbrg_rx_peer (
  // Requests from the bench
  input wire logic pinLvl,
  input wire logic pinGlitch,
  // Line into the block
  output logic serialReceivePin
);
  // A glitch flips the line only while it is requested
  assign serialReceivePin = pinLvl ^ pinGlitch;
endmodule

// [verif/tb.sv]
// Purpose: Self-checking bench for the serial baud rate generator.
// Assumes: Avalon answers come on waitrequest low; the bench never counts.
// Notes:   Tick divisors stay small (0..3) except the last mode's 8'hFF boundary case; 8'h5A is only written and read back.
`timescale 1ns/10ps
module tb;
  import sbrg_pkg::*;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdExp, rdMsk;
  logic serialReceivePin, baudTick, rxLevel, rateActive, pinLvl, pinGlitch;
  logic [31:0] rdQ[$], mkQ[$], perQ[$];
  logic [7:0] txv[4] = '{8'h00, 8'h04, 8'h94, 8'h90};
  int rt[4] = '{64, 16, 4, 4};
  integer seed = 32'h92E94CBC;
  int errorCnt = 0;
  int nCompared = 0;
  int sinceTick = 0;
  logic [7:0] n;

  sbrg_top sbrg_top_i (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .serialReceivePin(serialReceivePin), .baudTick(baudTick),
    .rxLevel(rxLevel), .rateActive(rateActive));
  sbrg_rx_peer sbrg_rx_peer_i (.pinLvl(pinLvl), .pinGlitch(pinGlitch),
    .serialReceivePin(serialReceivePin));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    if (errorCnt == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus(logic wr, logic [3:0] a, logic [7:0] d,
                     logic [3:0] be);
    int k;
    @(posedge core_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {24'($random(seed)), d};
    avs_byteenable <= be;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      errorCnt++;
      end_sim();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    bus(1'b1, a, d, 4'h1 | 4'($random(seed)));
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    rdQ.push_back(e);
    mkQ.push_back(m);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask

  // Ticks are looked for at the falling edge, clear of the drivers
  task automatic waitTick(int lim, logic want);
    int k;
    for (k = 0; k < lim; k++) begin
      @(negedge core_clk);
      if (baudTick === 1'b1) break;
    end
    chk("tick seen", {31'h0, want}, {31'h0, k < lim});
    // A tick that never came means a hang: report at once
    if (want && k == lim) begin
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rdQ.size() > 0) begin
      rdExp = rdQ.pop_front();
      rdMsk = mkQ.pop_front();
      chk("readdata", rdExp, avs_readdata & rdMsk);
    end
    if (baudTick === 1'b1) begin
      if (perQ.size() > 0) begin
        chk("tick interval", perQ.pop_front(), sinceTick);
      end
      sinceTick = 1;
    end else begin
      sinceTick++;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    pinLvl = 1'b1;
    pinGlitch = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(SBRG_OFS_TXCTL, 32'h02, '1);
    rd(SBRG_OFS_RXCTL, 32'h00, '1);
    rd(SBRG_OFS_DIV, 32'h00, '1);
    rd(SBRG_OFS_STAT, 32'h01, 32'h3);
    rd(4'h2, 32'h00, '1);
    wr(SBRG_OFS_TXCTL, 8'hFF);
    rd(SBRG_OFS_TXCTL, 32'hF7, '1);
    wr(SBRG_OFS_RXCTL, 8'hFF);
    rd(SBRG_OFS_RXCTL, 32'hF8, '1);
    bus(1'b1, SBRG_OFS_DIV, 8'hFF, 4'hE);
    rd(SBRG_OFS_DIV, 32'h00, '1);
    wr(SBRG_OFS_DIV, 8'h5A);
    rd(SBRG_OFS_DIV, 32'h5A, '1);
    wr(SBRG_OFS_RXCTL, 8'h80);
    // Last mode uses the top divisor as the boundary case
    for (int i = 0; i < 4; i++) begin
      wr(SBRG_OFS_TXCTL, txv[i]);
      n = (i == 3) ? 8'hFF : (8'($random(seed)) & 8'h03);
      wr(SBRG_OFS_DIV, n);
      waitTick((n + 1) * rt[i] + 3, 1'b1);
      @(posedge core_clk);
      @(negedge core_clk);
      perQ.push_back(32'((n + 1) * rt[i]));
      waitTick((n + 1) * rt[i] + 3, 1'b1);
      rd(SBRG_OFS_STAT, 32'h02, 32'h2);
    end
    wr(SBRG_OFS_TXCTL, 8'h10);
    wr(SBRG_OFS_DIV, 8'h00);
    waitTick(300, 1'b0);
    rd(SBRG_OFS_STAT, 32'h00, 32'h2);
    wr(SBRG_OFS_TXCTL, 8'h90);
    wr(SBRG_OFS_RXCTL, 8'h00);
    // A tick set on the disabling edge is still legal: let it pass
    @(posedge core_clk);
    waitTick(300, 1'b0);
    rd(SBRG_OFS_STAT, 32'h01, 32'h3);
    wr(SBRG_OFS_RXCTL, 8'h80);
    pinLvl <= 1'b0;
    repeat (40) @(posedge core_clk);
    rd(SBRG_OFS_STAT, 32'h00, 32'h1);
    // Four cycles high: exactly one sampler pick sees the glitch
    pinGlitch <= 1'b1;
    repeat (4) @(posedge core_clk);
    pinGlitch <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(SBRG_OFS_STAT, 32'h00, 32'h1);
    pinLvl <= 1'b1;
    repeat (40) @(posedge core_clk);
    rd(SBRG_OFS_STAT, 32'h01, 32'h1);
    repeat (3) @(posedge core_clk);
    end_sim();
  end
endmodule
